// file: level_sync.sv
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no word coherence is promised
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    // ==========================================
    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : level_sync

// file: sysref_pkg.sv
// types shared by the sysref window and aperture calibration block
// assumes the constants header is included by the design files
package sysref_pkg;

    // ==========================================
    // aperture delay setting: half-period invert, coarse, fine
    typedef struct packed {
        logic inv;
        logic [7:0] coarse;
        logic [7:0] fine;
    } apert_s;

    // ==========================================
    // calibration search states
    typedef enum logic [2:0] {
        CAL_IDLE,
        CAL_APPLY,
        CAL_SETTLE,
        CAL_CHECK,
        CAL_FINISH
    } cal_state_e;

endpackage : sysref_pkg

// file: sysref_source_model.sv
// clock source model: periodic sysref, tap view and edge comparator
// assumes the device clock is the bench clock and taps are async levels
`timescale 1ns/1ps
module sysref_source_model #(
    parameter int HALF = 16
) (
    // clock
    input wire logic clk_i,
    // stimulus control
    input wire logic run_i,
    input wire logic [23:0] pat_i,
    input wire logic [7:0] tgt0_i,
    input wire logic [7:0] tgt1_i,
    input wire sysref_pkg::apert_s apert_i,
    // analog side view
    output logic sysref_o,
    output logic [23:0] taps_o,
    output logic aligned_o
);
    int cnt;

    // ==========================================
    // sysref generation
    initial begin
        cnt = 0;
        sysref_o = 1'b0;
        aligned_o = 1'b0;
    end

    // continuous periodic sysref
    // a stopped source parks low, like a terminated line
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 0;
            sysref_o <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sysref_o <= ~sysref_o;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // later taps outside the pattern never see the pulse
    assign taps_o = sysref_o ? pat_i : 24'h000000;

    // ==========================================
    // comparator: one cycle late, as a real detector would be
    always @(posedge clk_i) begin
        aligned_o <= apert_i.inv ? (apert_i.coarse == tgt1_i) : (apert_i.coarse == tgt0_i);
    end
endmodule : sysref_source_model

// file: sysref_window_autocal.sv
// sysref windowing detector and automatic aperture delay calibration
// assumes delay-cell taps and an edge comparator from the analog side
// What this block does
// - measure sysref position, report status flags
// - flags valid after three sysref rising edges
// - flag one marks risky position, zero usable
// - lowest and highest positions always flagged
// - pick selects only positions 0 to 15
// - sample sysref at the picked delayed clock
// - step fine bit picks coarse or fine spacing
// - step delays until aligned, then raise done
// - report found delay in readable result
// - keep applying found delay until changed
// - search coarse with clock normal and inverted
// - invert bit adds half a clock period
// - coarse and fine each have 256 settings
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "sysref_window_autocal_consts.svh"
module sysref_window_autocal (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog side
    input wire logic [23:0] sysref_taps_i,
    input wire logic edge_aligned_i,
    output logic [3:0] sysref_phase_pick_o,
    output logic phase_step_fine_o,
    output logic sysref_captured_o,
    output sysref_pkg::apert_s apert_o,
    output logic autocal_done_o
);

    // ==========================================
    // pin synchronisers
    logic [23:0] taps_s;
    logic aligned_s;
    level_sync #(.W(24)) u_taps_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sysref_taps_i),
        .q_o(taps_s)
    );
    level_sync #(.W(1)) u_align_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(edge_aligned_i),
        .q_o(aligned_s)
    );

    // ==========================================
    // register state
    logic [3:0] pick;
    logic zoom;
    sysref_pkg::apert_s apert_reg;
    logic autocal_enable;
    logic [7:0] autocal_config;
    sysref_pkg::apert_s result;
    logic done;
    logic nolock;

    // ==========================================
    // bus decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire hit_ctrl = (wb_adr_i == `ADR_CTRL);
    wire hit_apert = (wb_adr_i == `ADR_APERT);
    wire hit_en = (wb_adr_i == `ADR_EN);
    wire hit_cfg = (wb_adr_i == `ADR_CFG);
    wire wr_ctrl = wr & hit_ctrl & wb_sel_i[0];
    wire wr_en = wr & hit_en & wb_sel_i[0];
    wire wr_cfg = wr & hit_cfg & wb_sel_i[0];
    wire [2:0] wr_apert = {3{wr & hit_apert}} & wb_sel_i[2:0];
    wire en_lowered = wr_en & ~wb_dat_i[0];

    // ==========================================
    // windowing detector
    logic ref_prev;
    logic [23:0] cap;
    logic [23:0] flags;
    logic [1:0] edge_cnt;
    logic flags_valid;

    // tap 0 is the earliest sample, so its rise marks each sysref edge
    wire ref_rise = taps_s[0] & ~ref_prev;
    wire [23:0] next_flags = (taps_s ^ {taps_s[22:0], taps_s[0]})
                           | (taps_s ^ {taps_s[23], taps_s[23:1]})
                           | (taps_s ^ cap)
                           | `FLAG_ENDS; // ends always flagged

    // a set flag marks a position near the sysref edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_prev <= 1'b0;
            cap <= '0;
            flags <= `FLAG_ENDS;
        end else begin
            ref_prev <= taps_s[0];
            if (ref_rise) begin
                cap <= taps_s;
                flags <= next_flags;
            end
        end
    end

    // count edges before trusting the flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_cnt <= '0;
            flags_valid <= 1'b0;
        end else if (ref_rise && edge_cnt != `EDGES_NEEDED) begin
            edge_cnt <= edge_cnt + 2'h1;
            flags_valid <= (edge_cnt == `EDGES_NEEDED - 2'h1);
        end
    end

    // capture sysref on the picked delayed tap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysref_captured_o <= 1'b0;
        end else begin
            sysref_captured_o <= taps_s[pick];
        end
    end

    // ==========================================
    // calibration search
    sysref_pkg::cal_state_e state;
    logic srch_inv;
    logic [7:0] srch_coarse;
    logic [7:0] settle_cnt;
    logic found;
    logic best_inv;
    logic [7:0] best_coarse;

    wire busy = (state != sysref_pkg::CAL_IDLE);
    wire finish = (state == sysref_pkg::CAL_FINISH);
    // the inverted pass only helps while it stays below the normal result
    wire no_gain = srch_inv & found & (srch_coarse == best_coarse);

    // step until the falling edge meets sysref
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= sysref_pkg::CAL_IDLE;
            srch_inv <= 1'b0;
            srch_coarse <= '0;
            settle_cnt <= '0;
            found <= 1'b0;
            best_inv <= 1'b0;
            best_coarse <= '0;
        end else if (!autocal_enable) begin
            state <= sysref_pkg::CAL_IDLE;
        end else begin
            case (state)
                sysref_pkg::CAL_IDLE: begin
                    if (!done) begin
                        srch_inv <= 1'b0;
                        srch_coarse <= '0;
                        found <= 1'b0;
                        best_inv <= 1'b0;
                        best_coarse <= '0;
                        state <= sysref_pkg::CAL_APPLY;
                    end
                end
                sysref_pkg::CAL_APPLY: begin
                    settle_cnt <= autocal_config;
                    state <= sysref_pkg::CAL_SETTLE;
                end
                sysref_pkg::CAL_SETTLE: begin
                    if (settle_cnt == '0) begin
                        state <= sysref_pkg::CAL_CHECK;
                    end else begin
                        settle_cnt <= settle_cnt - 8'h01;
                    end
                end
                sysref_pkg::CAL_CHECK: begin
                    if (no_gain) begin
                        state <= sysref_pkg::CAL_FINISH;
                    end else if (aligned_s) begin
                        found <= 1'b1;
                        best_inv <= srch_inv;
                        best_coarse <= srch_coarse;
                        if (!srch_inv) begin
                            srch_inv <= 1'b1;
                            srch_coarse <= '0;
                            state <= sysref_pkg::CAL_APPLY;
                        end else begin
                            state <= sysref_pkg::CAL_FINISH;
                        end
                    end else if (srch_coarse == `COARSE_LAST) begin
                        if (!srch_inv) begin
                            srch_inv <= 1'b1;
                            srch_coarse <= '0;
                            state <= sysref_pkg::CAL_APPLY;
                        end else begin
                            state <= sysref_pkg::CAL_FINISH;
                        end
                    end else begin
                        srch_coarse <= srch_coarse + 8'h01;
                        state <= sysref_pkg::CAL_APPLY;
                    end
                end
                default: begin
                    state <= sysref_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pick <= `PICK_RST;
            zoom <= 1'b0;
            autocal_enable <= 1'b0;
            autocal_config <= `CFG_RST;
        end else begin
            // only four bits, positions 0 to 15
            if (wr_ctrl) begin
                pick <= wb_dat_i[3:0];
                zoom <= wb_dat_i[`CTRL_FINE_BIT];
            end
            if (wr_en) begin
                autocal_enable <= wb_dat_i[0];
            end
            if (wr_cfg) begin
                autocal_config <= wb_dat_i[7:0];
            end
        end
    end

    // found delay loads the manual setting; hardware wins a tie
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            apert_reg <= '0;
        end else if (finish) begin
            apert_reg <= result;
        end else begin
            // eight bits each for coarse and fine
            if (wr_apert[0]) apert_reg.fine <= wb_dat_i[7:0];
            if (wr_apert[1]) apert_reg.coarse <= wb_dat_i[15:8];
            if (wr_apert[2]) apert_reg.inv <= wb_dat_i[16];
        end
    end

    // done set at finish wins over clear; nolock changes only at finish
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
            nolock <= 1'b0;
        end else if (finish) begin
            done <= 1'b1;
            nolock <= ~found;
        end else if (en_lowered) begin
            done <= 1'b0;
        end
    end

    // result is tracked live so it is settled when finish fires
    assign result = '{inv: best_inv & found, coarse: found ? best_coarse : 8'h00,
                      fine: apert_reg.fine};

    // ==========================================
    // analog outputs
    // invert bit passes straight to the half-period stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            apert_o <= '0;
            sysref_phase_pick_o <= `PICK_RST;
            phase_step_fine_o <= 1'b0;
            autocal_done_o <= 1'b0;
        end else begin
            apert_o <= busy ? sysref_pkg::apert_s'{inv: srch_inv, coarse: srch_coarse, fine: apert_reg.fine}
                            : apert_reg;
            sysref_phase_pick_o <= pick;
            phase_step_fine_o <= zoom;
            autocal_done_o <= done;
        end
    end

    // ==========================================
    // read mux and acknowledge
    wire [31:0] stat_word = {28'h0, nolock, busy, flags_valid, done};
    wire [31:0] rd_data = hit_ctrl ? {27'h0, zoom, pick}
                        : hit_apert ? {15'h0, apert_reg}
                        : hit_en ? {31'h0, autocal_enable}
                        : hit_cfg ? {24'h0, autocal_config}
                        : (wb_adr_i == `ADR_RESULT) ? {15'h0, result}
                        : (wb_adr_i == `ADR_STAT) ? stat_word
                        : (wb_adr_i == `ADR_FLAGS) ? {8'h0, flags}
                        : 32'h0;

    // unmapped addresses still ack, reading zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : 32'h0;
        end
    end

    // ==========================================
    // assertions
    AST_ENDS: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_valid |-> (flags[0] && flags[23]))
        else $error("end positions not flagged");
    AST_VALID_AFTER_THREE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(flags_valid) |-> ($past(ref_rise) && $past(edge_cnt) == 2'h2))
        else $error("flags valid before third edge");
    AST_FLAG_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_rise && taps_s[8] != taps_s[7]) |=> (flags[8] && flags[7]))
        else $error("transition not flagged");
    AST_PICK_SAMPLE: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (sysref_captured_o == $past(taps_s[pick])))
        else $error("sysref not sampled at picked tap");
    AST_PICK_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ##1 (sysref_phase_pick_o == $past(wb_dat_i[3:0], 2)))
        else $error("pick not applied");
    AST_STEP_FINE: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ##1 (phase_step_fine_o == $past(wb_dat_i[`CTRL_FINE_BIT], 2)))
        else $error("step spacing not applied");
    AST_INVERT_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == sysref_pkg::CAL_CHECK && aligned_s && !srch_inv && autocal_enable)
        |=> (srch_inv && srch_coarse == 8'h00 && state == sysref_pkg::CAL_APPLY))
        else $error("inverted pass skipped");
    AST_DONE_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(done) |-> (apert_reg == $past(result) && !busy))
        else $error("result not reported at done");
    AST_KEEP_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
        (done && !busy) [*2] |-> (apert_o == $past(apert_reg)))
        else $error("found delay not held");
    AST_DONE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (en_lowered && !finish) |=> !done ##1 !autocal_done_o)
        else $error("done not cleared");
    AST_DONE_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        finish |=> done ##1 autocal_done_o)
        else $error("done not raised after search");

    COV_VALID: cover property (@(posedge clk_i) disable iff (rst_i) $rose(flags_valid));
    COV_DONE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(done) && !nolock);
    COV_INV_WIN: cover property (@(posedge clk_i) disable iff (rst_i) finish && best_inv);
    COV_NOLOCK: cover property (@(posedge clk_i) disable iff (rst_i) finish && !found);

endmodule : sysref_window_autocal

// file: sysref_window_autocal_consts.svh
// constants for the sysref window and aperture calibration block
// assumes a 32-bit wishbone word per register, byte addresses
`ifndef SYSREF_WINDOW_AUTOCAL_CONSTS_SVH
`define SYSREF_WINDOW_AUTOCAL_CONSTS_SVH

// ==========================================
// register byte addresses
`define ADR_CTRL 8'h00
`define ADR_APERT 8'h04
`define ADR_EN 8'h08
`define ADR_CFG 8'h0C
`define ADR_RESULT 8'h10
`define ADR_STAT 8'h14
`define ADR_FLAGS 8'h2C

// ==========================================
// field positions and reset values
`define CTRL_FINE_BIT 4
`define STAT_DONE_BIT 0
`define STAT_VALID_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_NOLOCK_BIT 3
`define PICK_RST 4'h0
`define CFG_RST 8'h10
`define COARSE_LAST 8'hFF
`define FLAG_ENDS 24'h800001
`define EDGES_NEEDED 2'h3

`endif

// file: tb.sv
// self-checking bench for the sysref window and calibration block
// assumes a 250 MHz clock and the source model beside the block
`timescale 1ns/1ps
module tb;
    // ==========================================
    // clock, bus and model wiring
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h00000000;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic run = 1'b0;
    logic [23:0] taps;
    logic aligned;
    logic sysref;
    logic [3:0] pick;
    logic fine;
    logic captured;
    logic done;
    sysref_pkg::apert_s apert;
    logic [31:0] rd;
    int err_count = 0;
    int n_compared = 0;

    always #2 clk = ~clk;

    sysref_window_autocal uut (
        .clk_i(clk), .rst_i(rst),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .sysref_taps_i(taps), .edge_aligned_i(aligned), .sysref_phase_pick_o(pick),
        .phase_step_fine_o(fine), .sysref_captured_o(captured), .apert_o(apert),
        .autocal_done_o(done)
    );

    // only inv=1 coarse 5 beats the plain hit at coarse 9
    sysref_source_model src (
        .clk_i(clk), .run_i(run), .pat_i(24'h0000FF), .tgt0_i(8'h09), .tgt1_i(8'h05),
        .apert_i(apert), .sysref_o(sysref), .taps_o(taps), .aligned_o(aligned)
    );

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // classic cycle: hold everything until ack is sampled high
    // waits as long as it takes; only the watchdog ends a hung cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= d;
        wb_sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // ==========================================
    // scenarios
    task automatic reset_values();
        wb(1'b0, 8'h2C, 32'h0);
        check(rd, 32'h00800001);
        wb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h00000010);
        wb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h00000000);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        wb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h00000000);
        check({31'h0, done}, 32'h0);
    endtask : reset_values

    // flags must not be trusted before the third sysref rise
    task automatic window_valid();
        run <= 1'b1;
        repeat (2) @(posedge sysref);
        repeat (8) @(posedge clk);
        wb(1'b0, 8'h14, 32'h0);
        check(rd & 32'h2, 32'h0);
        @(posedge sysref);
        repeat (8) @(posedge clk);
        wb(1'b0, 8'h14, 32'h0);
        check(rd & 32'h2, 32'h2);
        wb(1'b0, 8'h2C, 32'h0);
        check(rd, 32'h00800181);
    endtask : window_valid

    task automatic pick_select();
        wb(1'b1, 8'h00, 32'h1F);
        wb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000001F);
        check({27'h0, fine, pick}, 32'h1F);
        @(posedge sysref);
        repeat (6) @(posedge clk);
        check({31'h0, captured}, 32'h0);
        // middle of usable run 1 to 6
        wb(1'b1, 8'h00, 32'h03);
        @(posedge clk);
        check({27'h0, fine, pick}, 32'h03);
        @(posedge sysref);
        repeat (6) @(posedge clk);
        check({31'h0, captured}, 32'h1);
        @(negedge sysref);
        repeat (6) @(posedge clk);
        check({31'h0, captured}, 32'h0);
    endtask : pick_select

    task automatic autocal_run();
        int n;
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'h33);
        wb(1'b1, 8'h0C, 32'h06);
        wb(1'b1, 8'h08, 32'h1);
        for (n = 0; n < 3000 && done !== 1'b1; n++) begin
            @(posedge clk);
        end
        check({31'h0, done}, 32'h1);
        wb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h00010533);
        check({15'h0, apert}, 32'h00010533);
        wb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h00000003);
        wb(1'b1, 8'h08, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, done}, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h00000002);
        check({15'h0, apert}, 32'h00010533);
        wb(1'b1, 8'h04, 32'h0001FF07);
        @(posedge clk);
        check({15'h0, apert}, 32'h0001FF07);
    endtask : autocal_run

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        window_valid();
        pick_select();
        autocal_run();
        complete_run();
    end

    // roughly seventy times the expected run
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule : tb
